// ---- common/clk_rst_pkg.sv ----
// constants for the video source clock and reset control block
package clk_rst_pkg;
  // register byte offsets
  localparam logic [7:0] ctrl_off = 8'h00;
  localparam logic [7:0] pixel_khz_off = 8'h04;
  localparam logic [7:0] lane_khz_off = 8'h08;
  localparam logic [7:0] link_khz_off = 8'h0c;
  localparam logic [7:0] vid_khz_off = 8'h10;
  localparam logic [7:0] frl_khz_off = 8'h14;
  localparam logic [7:0] status_off = 8'h18;
  localparam logic [7:0] vid_count_off = 8'h1c;
  localparam logic [7:0] aud_count_off = 8'h20;
  // control field positions
  localparam int depth_lsb = 0;
  localparam int ycc420_bit = 2;
  localparam int frl_rate_lsb = 3;
  // values after reset
  localparam logic [5:0] ctrl_rst = 6'h00;
  localparam logic [31:0] pixel_khz_rst = 32'h00000000;
  // clock arithmetic
  localparam logic [31:0] tmds_bits_per_char = 32'h0000000a;
  localparam logic [31:0] link_clk_div = 32'h00000014;
  localparam logic [31:0] xcvr_width_tmds = 32'h00000014;
  localparam logic [31:0] xcvr_width_frl = 32'h00000028;
  localparam logic [31:0] frl_lanes = 32'h00000004;
  localparam logic [31:0] frl_chars_per_clk = 32'h00000010;
  localparam logic [31:0] frl_char_bits = 32'h00000012;
  localparam logic [31:0] khz_per_gbps = 32'h000f4240;
  // color depth ratio in quarters for 8, 10, 12, 16 bits per component
  localparam logic [3:0] ratio_q8 = 4'h4;
  localparam logic [3:0] ratio_q10 = 4'h5;
  localparam logic [3:0] ratio_q12 = 4'h6;
  localparam logic [3:0] ratio_q16 = 4'h8;
  localparam logic [3:0] all_lanes = 4'hf;
  localparam logic [3:0] three_lanes = 4'h7;
  localparam int sync_stages = 2;
endpackage

// ---- logic/clk_rst_ctrl.sv ----
// clock and reset control for a video link source, with apb registers
// ==========================================================
// Operation
// - main reset input asserts asynchronously and clears the accept outputs and counts; core_rst_out is registered and asserts on the next mclk edge.
// - separate video reset input exists only without fixed-rate-link support.
// - lane rate equals pixel frequency times 10 times color depth ratio.
// - link speed clock input is not used with fixed-rate-link support.
// - with fixed-rate-link video words are taken only while video valid is high.
// - arithmetic uses four lanes; rates 1 and 2 drive only three lanes.
// - transceiver width is 20 without and 40 with fixed-rate-link support.
// - fixed-rate-link path handles 16 characters of 18 bits per clock.
//
// The register offsets and the APB register port were decided locally.
`timescale 1ns/100ps
`default_nettype none
module clk_rst_ctrl #(
  parameter bit support_frl = 1'b0
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // reset pins
  input wire logic core_reset_in,
  input wire logic vid_reset_in,
  // qualifier pins
  input wire logic vid_valid_in,
  input wire logic audio_data_qualifier,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // reset, link clock, lane enable and qualifier outputs
  output logic core_rst_out,
  output logic vid_rst_out,
  output logic link_clk_used,
  output logic [3:0] lane_enable,
  output logic vid_accept,
  output logic audio_accept
);
  // ==========================================================
  // reset synchronisers: outputs assert on the next mclk edge, release on the third edge
  logic [1:0] core_sync_reg;
  logic [1:0] vid_sync_reg;
  logic vid_async;
  assign vid_async = core_reset_in | (!support_frl & vid_reset_in);

  always_ff @(posedge mclk or posedge core_reset_in) begin
    if (core_reset_in) begin
      core_sync_reg <= 2'h3;
    end else if (rst) begin
      core_sync_reg <= 2'h3;
    end else begin
      core_sync_reg <= {core_sync_reg[0], 1'b0};
    end
  end

  always_ff @(posedge mclk or posedge vid_async) begin
    if (vid_async) begin
      vid_sync_reg <= 2'h3;
    end else if (rst) begin
      vid_sync_reg <= 2'h3;
    end else begin
      vid_sync_reg <= {vid_sync_reg[0], 1'b0};
    end
  end

  always_ff @(posedge mclk) begin
    core_rst_out <= core_sync_reg[1];
    vid_rst_out <= vid_sync_reg[1];
  end

  // ==========================================================
  // qualifier pins pass two flip-flops first
  logic [1:0] vvalid_sync_reg;
  logic [1:0] aq_sync_reg;
  always_ff @(posedge mclk) begin
    if (rst) begin
      vvalid_sync_reg <= 2'h0;
      aq_sync_reg <= 2'h0;
    end else begin
      vvalid_sync_reg <= {vvalid_sync_reg[0], vid_valid_in};
      aq_sync_reg <= {aq_sync_reg[0], audio_data_qualifier};
    end
  end

  // ==========================================================
  // control registers
  logic [5:0] ctrl_reg;
  logic [31:0] pixel_khz_reg;
  logic [31:0] vid_count_reg;
  logic [31:0] aud_count_reg;
  logic wr_en;
  logic access;
  assign access = psel & penable & !pready;
  assign wr_en = access & pwrite;

  always_ff @(posedge mclk) begin
    if (rst) begin
      ctrl_reg <= clk_rst_pkg::ctrl_rst;
      pixel_khz_reg <= clk_rst_pkg::pixel_khz_rst;
    end else if (wr_en) begin
      if (paddr == clk_rst_pkg::ctrl_off) begin
        ctrl_reg <= pwdata[5:0];
      end
      if (paddr == clk_rst_pkg::pixel_khz_off) begin
        pixel_khz_reg <= pwdata;
      end
    end
  end

  // ==========================================================
  // clock arithmetic
  logic [3:0] ratio_q;
  logic [2:0] frl_rate;
  logic [31:0] frl_gbps;
  logic [31:0] lane_khz;
  logic [31:0] link_khz;
  logic [31:0] vid_khz;
  logic [31:0] frl_khz;
  logic [31:0] xcvr_width;
  assign frl_rate = ctrl_reg[clk_rst_pkg::frl_rate_lsb +: 3];
  // width follows the build option
  assign xcvr_width = support_frl ? clk_rst_pkg::xcvr_width_frl
                                  : clk_rst_pkg::xcvr_width_tmds;

  always_comb begin
    case (ctrl_reg[clk_rst_pkg::depth_lsb +: 2])
      2'h0: ratio_q = clk_rst_pkg::ratio_q8;
      2'h1: ratio_q = clk_rst_pkg::ratio_q10;
      2'h2: ratio_q = clk_rst_pkg::ratio_q12;
      default: ratio_q = clk_rst_pkg::ratio_q16;
    endcase
  end

  always_comb begin
    case (frl_rate)
      3'h1: frl_gbps = 32'h00000003;
      3'h2: frl_gbps = 32'h00000006;
      3'h3: frl_gbps = 32'h00000006;
      3'h4: frl_gbps = 32'h00000008;
      3'h5: frl_gbps = 32'h0000000a;
      3'h6: frl_gbps = 32'h0000000c;
      default: frl_gbps = 32'h00000000;
    endcase
  end

  // quarters keep fractional ratios exact; the video rate also divides by ratio_q from ctrl_reg
  assign lane_khz = 32'((pixel_khz_reg * clk_rst_pkg::tmds_bits_per_char
                         * {28'h0, ratio_q}) >> 2);
  assign link_khz = support_frl ? 32'h0 : lane_khz / clk_rst_pkg::link_clk_div;
  assign vid_khz = 32'((((lane_khz << 2) / xcvr_width) / {28'h0, ratio_q})
                       >> (ctrl_reg[clk_rst_pkg::ycc420_bit] ? 1 : 0));
  assign frl_khz = 32'((frl_gbps * clk_rst_pkg::khz_per_gbps * clk_rst_pkg::frl_lanes)
                       / (clk_rst_pkg::frl_chars_per_clk
                          * clk_rst_pkg::frl_char_bits));

  always_ff @(posedge mclk) begin
    if (rst) begin
      lane_enable <= 4'h0;
      link_clk_used <= 1'b0;
    end else begin
      link_clk_used <= !support_frl & !core_sync_reg[1];
      if (!support_frl || frl_rate == 3'h0) begin
        lane_enable <= clk_rst_pkg::three_lanes;
      end else if (frl_rate <= 3'h2) begin
        lane_enable <= clk_rst_pkg::three_lanes;
      end else begin
        lane_enable <= clk_rst_pkg::all_lanes;
      end
    end
  end

  // ==========================================================
  // data qualification; counts give software a view of the rate
  always_ff @(posedge mclk) begin
    if (rst || vid_sync_reg[1]) begin
      vid_accept <= 1'b0;
      vid_count_reg <= 32'h0;
    end else begin
      vid_accept <= support_frl ? vvalid_sync_reg[1] : 1'b1;
      if (support_frl ? vvalid_sync_reg[1] : 1'b1) begin
        vid_count_reg <= vid_count_reg + 32'h1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst || core_sync_reg[1]) begin
      audio_accept <= 1'b0;
      aud_count_reg <= 32'h0;
    end else begin
      audio_accept <= aq_sync_reg[1];
      if (aq_sync_reg[1]) begin
        aud_count_reg <= aud_count_reg + 32'h1;
      end
    end
  end

  // ==========================================================
  // apb answer: one wait state, unmapped addresses flag an error
  logic [31:0] rd_mux;
  logic hit;
  always_comb begin
    hit = 1'b1;
    rd_mux = 32'h0;
    case (paddr)
      clk_rst_pkg::ctrl_off: rd_mux = {26'h0, ctrl_reg};
      clk_rst_pkg::pixel_khz_off: rd_mux = pixel_khz_reg;
      clk_rst_pkg::lane_khz_off: rd_mux = lane_khz;
      clk_rst_pkg::link_khz_off: rd_mux = link_khz;
      clk_rst_pkg::vid_khz_off: rd_mux = vid_khz;
      clk_rst_pkg::frl_khz_off: rd_mux = support_frl ? frl_khz : 32'h0;
      clk_rst_pkg::status_off:
        rd_mux = {24'h0, lane_enable, support_frl, link_clk_used, vid_rst_out, core_rst_out};
      clk_rst_pkg::vid_count_off: rd_mux = vid_count_reg;
      clk_rst_pkg::aud_count_off: rd_mux = aud_count_reg;
      default: hit = 1'b0;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      pready <= access;
      pslverr <= access & !hit;
      prdata <= (access & !pwrite) ? rd_mux : 32'h0;
    end
  end

  // ==========================================================
  // assertions
  a_core_reset_hold: assert property (@(posedge mclk) disable iff (rst)
    core_reset_in |-> ##[1:2] core_rst_out) else $error("core reset not passed");
  a_core_release_sync: assert property (@(posedge mclk) disable iff (rst)
    $fell(core_rst_out) |-> !$past(core_reset_in, 3)) else $error("early release");
  // core_reset_in sets and releases both chains together, so the video reset covers the core reset
  a_vid_follows_core: assert property (@(posedge mclk) disable iff (rst)
    core_rst_out |-> vid_rst_out) else $error("video reset missed core reset");
  a_vid_reset_gate: assert property (@(posedge mclk) disable iff (rst)
    (support_frl && !core_rst_out && !core_reset_in) [*3] |-> !vid_rst_out)
    else $error("video reset used with frl");
  a_link_clk_unused: assert property (@(posedge mclk) disable iff (rst)
    support_frl |-> !link_clk_used) else $error("link clock used with frl");
  a_valid_gates_vid: assert property (@(posedge mclk) disable iff (rst)
    (support_frl && vid_accept) |-> $past(vvalid_sync_reg[1])) else $error("bad accept");
  a_lanes_low_rate: assert property (@(posedge mclk) disable iff (rst)
    (frl_rate inside {3'h1, 3'h2}) ##1 (frl_rate inside {3'h1, 3'h2})
    |-> lane_enable == 4'h7) else $error("fourth lane on");
  a_lane_rate_math: assert property (@(posedge mclk) disable iff (rst)
    (ctrl_reg[1:0] == 2'h1 && pixel_khz_reg < 32'h04000000)
    |-> (lane_khz == ((pixel_khz_reg * 32'h19) >> 1)))
    else $error("lane rate wrong");
  a_width_choice: assert property (@(posedge mclk) disable iff (rst)
    xcvr_width == (support_frl ? 32'h28 : 32'h14)) else $error("width wrong");
  a_frl_chars: assert property (@(posedge mclk) disable iff (rst)
    (frl_rate == 3'h6) |-> (frl_khz == 32'h00028b0a)) else $error("frl clock wrong");

  c_core_release: cover property (@(posedge mclk) $fell(core_rst_out));
  c_vid_accept: cover property (@(posedge mclk) vid_accept ##1 !vid_accept);
  c_apb_error: cover property (@(posedge mclk) pready && pslverr);
  c_audio_accept: cover property (@(posedge mclk) audio_accept);
endmodule
`default_nettype wire

// ---- verif/av_source_model.sv ----
// far-side model of the audio sample source feeding the qualifier pin
`timescale 1ns/100ps
`default_nettype none
module av_source_model (
  // clock
  input wire logic mclk,
  input wire logic rst,
  // bench control
  input wire logic hold,
  input wire logic go,
  input wire logic [7:0] burst,
  // qualifier pin
  output logic qual
);
  logic [8:0] left_reg;
  // ==========================================================
  // slow source: one sample every other cycle
  always_ff @(posedge mclk) begin
    if (rst) begin
      left_reg <= 9'h000;
    end else if (go) begin
      left_reg <= {burst, 1'b0};
    end else if (left_reg != 9'h000) begin
      left_reg <= left_reg - 9'h001;
    end
  end
  // hold mode stands for a clock at the sample rate itself
  assign qual = hold | left_reg[0];
endmodule
`default_nettype wire

// ---- verif/tb_top.sv ----
// self-checking bench for the clock and reset control block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic mclk, rst, core_reset_in, vid_reset_in, vid_valid_in, aq, hold, go;
  logic psel, penable, pwrite, pready, pslverr, core_rst_out, vid_rst_out;
  logic link_clk_used, vid_accept, audio_accept, err;
  logic [7:0] paddr, burst;
  logic [31:0] pwdata, prdata, rd, rnd, pix, c0;
  logic [3:0] lane_enable, q;
  logic [5:0] ctl;
  logic pready_f, pslverr_f, core_rst_out_f, vid_rst_out_f, link_clk_used_f, vid_accept_f;
  logic audio_accept_f, err_f;
  logic [31:0] prdata_f, rd_f;
  logic [3:0] lane_enable_f;
  int mismatches, cmp_count, cycles;
  clk_rst_ctrl dut (.mclk(mclk), .rst(rst), .core_reset_in(core_reset_in),
    .vid_reset_in(vid_reset_in), .vid_valid_in(vid_valid_in), .audio_data_qualifier(aq),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .core_rst_out(core_rst_out),
    .vid_rst_out(vid_rst_out), .link_clk_used(link_clk_used), .lane_enable(lane_enable),
    .vid_accept(vid_accept), .audio_accept(audio_accept));
  // second build with fixed-rate-link support, sharing every input
  clk_rst_ctrl #(.support_frl(1'b1)) dut_frl (.mclk(mclk), .rst(rst),
    .core_reset_in(core_reset_in), .vid_reset_in(vid_reset_in), .vid_valid_in(vid_valid_in),
    .audio_data_qualifier(aq), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata_f), .pready(pready_f),
    .pslverr(pslverr_f), .core_rst_out(core_rst_out_f), .vid_rst_out(vid_rst_out_f),
    .link_clk_used(link_clk_used_f), .lane_enable(lane_enable_f),
    .vid_accept(vid_accept_f), .audio_accept(audio_accept_f));
  av_source_model src (.mclk(mclk), .rst(rst), .hold(hold), .go(go), .burst(burst),
    .qual(aq));
  // ==========================================================
  // helpers
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function automatic logic [3:0] ratio(input logic [1:0] d);
    case (d)
      2'h0: return clk_rst_pkg::ratio_q8;
      2'h1: return clk_rst_pkg::ratio_q10;
      2'h2: return clk_rst_pkg::ratio_q12;
      default: return clk_rst_pkg::ratio_q16;
    endcase
  endfunction
  function automatic logic [31:0] frl_exp(input logic [2:0] r);
    logic [31:0] g;
    case (r)
      3'h1: g = 32'd3;
      3'h2: g = 32'd6;
      3'h3: g = 32'd6;
      3'h4: g = 32'd8;
      3'h5: g = 32'd10;
      3'h6: g = 32'd12;
      default: g = 32'd0;
    endcase
    return (g * clk_rst_pkg::khz_per_gbps * clk_rst_pkg::frl_lanes)
           / (clk_rst_pkg::frl_chars_per_clk * clk_rst_pkg::frl_char_bits);
  endfunction
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic finish_test();
    $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // request held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    rd_f = prdata_f;
    err_f = pslverr_f;
    chk("pready frl", 32'h1, {31'h0, pready_f});
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) chk("pready", 32'h1, 32'h0);
  endtask
  // ==========================================================
  // clock, timeout, random qualifier
  initial begin
    mclk = 1'b0;
    // one mclk stands in for link, video, transceiver and audio clocks
    forever #50 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cycles++;
    vid_valid_in <= rnd[7];
    if (cycles > 20000) begin
      mismatches++;
      finish_test();
    end
  end
  task automatic pin_reset(input logic vid);
    @(posedge mclk);
    if (vid) vid_reset_in <= 1'b1;
    else core_reset_in <= 1'b1;
    repeat (3) @(posedge mclk);
    chk("vid_rst_out", 32'h1, {31'h0, vid_rst_out});
    chk("vid_rst_out frl", {31'h0, !vid}, {31'h0, vid_rst_out_f});
    chk("core_rst_out", {31'h0, !vid}, {31'h0, core_rst_out});
    chk("core_rst_out frl", {31'h0, !vid}, {31'h0, core_rst_out_f});
    core_reset_in <= 1'b0;
    vid_reset_in <= 1'b0;
    repeat (3) @(posedge mclk);
    chk("vid_rst_out held", 32'h1, {31'h0, vid_rst_out});
    @(posedge mclk);
    chk("vid_rst_out free", 32'h0, {31'h0, vid_rst_out});
  endtask
  // ==========================================================
  // main sequence
  initial begin
    {rst, core_reset_in, vid_reset_in, vid_valid_in, hold, go, psel, penable, pwrite} = '0;
    rst = 1'b1;
    {paddr, burst, pwdata} = '0;
    rnd = 32'd79;
    mismatches = 0;
    cmp_count = 0;
    cycles = 0;
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    apb(1'b0, clk_rst_pkg::ctrl_off, 32'h0);
    chk("ctrl reset", 32'h0, rd);
    apb(1'b0, clk_rst_pkg::status_off, 32'h0);
    chk("status", 32'h74, rd);
    chk("status frl", 32'h78, rd_f);
    chk("lane_enable", 32'h7, {28'h0, lane_enable});
    chk("vid_accept", 32'h1, {31'h0, vid_accept});
    for (int i = 0; i < 12; i++) begin
      rnd = lfsr(rnd);
      ctl = {rnd[5:2], 2'(i)};
      pix = rnd & 32'h0001fff8;
      q = ratio(ctl[1:0]);
      apb(1'b1, clk_rst_pkg::ctrl_off, {rnd[31:6], ctl});
      apb(1'b1, clk_rst_pkg::pixel_khz_off, pix);
      apb(1'b0, clk_rst_pkg::ctrl_off, 32'h0);
      chk("ctrl", {26'h0, ctl}, rd);
      apb(1'b0, clk_rst_pkg::lane_khz_off, 32'h0);
      chk("lane khz", pix * 10 * q / 4, rd);
      apb(1'b0, clk_rst_pkg::link_khz_off, 32'h0);
      chk("link khz", pix * q / 8, rd);
      chk("link khz frl", 32'h0, rd_f);
      apb(1'b0, clk_rst_pkg::vid_khz_off, 32'h0);
      chk("video khz", ctl[2] ? pix / 4 : pix / 2, rd);
      chk("video khz frl", ctl[2] ? pix / 8 : pix / 4, rd_f);
      apb(1'b0, clk_rst_pkg::frl_khz_off, 32'h0);
      chk("frl khz", 32'h0, rd);
      chk("frl khz frl", frl_exp(ctl[5:3]), rd_f);
      chk("lanes frl", (ctl[5:3] >= 3'h3) ? 32'hf : 32'h7, {28'h0, lane_enable_f});
      chk("vid_accept frl", {31'h0, rnd[7]}, {31'h0, vid_accept_f});
    end
    apb(1'b1, clk_rst_pkg::lane_khz_off, 32'h0);
    apb(1'b0, clk_rst_pkg::lane_khz_off, 32'h0);
    chk("ro lane khz", pix * 10 * q / 4, rd);
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped data", 32'h0, rd);
    chk("unmapped err", 32'h1, {31'h0, err});
    chk("unmapped err frl", 32'h1, {31'h0, err_f});
    apb(1'b0, clk_rst_pkg::aud_count_off, 32'h0);
    c0 = rd;
    burst <= 8'h05;
    go <= 1'b1;
    @(posedge mclk);
    go <= 1'b0;
    repeat (15) @(posedge mclk);
    hold <= 1'b1;
    repeat (10) @(posedge mclk);
    chk("audio_accept", 32'h1, {31'h0, audio_accept});
    chk("audio_accept frl", 32'h1, {31'h0, audio_accept_f});
    hold <= 1'b0;
    repeat (6) @(posedge mclk);
    apb(1'b0, clk_rst_pkg::aud_count_off, 32'h0);
    chk("audio count", c0 + 32'd15, rd);
    pin_reset(1'b1);
    pin_reset(1'b0);
    apb(1'b0, clk_rst_pkg::aud_count_off, 32'h0);
    chk("audio count cleared", 32'h0, rd);
    chk("link_clk_used", 32'h1, {31'h0, link_clk_used});
    chk("link_clk_used frl", 32'h0, {31'h0, link_clk_used_f});
    finish_test();
  end
endmodule
`default_nettype wire
